// ==== inc/besp_regs.svh ====
`ifndef BESP_REGS_SVH
`define BESP_REGS_SVH
// Register byte addresses
`define BESP_ADDR_STATUS 12'h068
`define BESP_ADDR_OPTION 12'h074
`define BESP_ADDR_RETRY 12'h078
// Status cause bit positions within the status word
`define BESP_ST_ADDR_PAR 16
`define BESP_ST_CAUSE_LSB 16
`define BESP_ST_CAUSE_MSB 23
// Byte lane that carries the status causes
`define BESP_ST_STRB_LANE 2
// Option bit positions
`define BESP_OPT_P_RD_ALIAS 1
`define BESP_OPT_P_WR_ALIAS 2
`define BESP_OPT_S_RD_ALIAS 3
`define BESP_OPT_S_WR_ALIAS 4
`define BESP_OPT_P_MWI_DISC 7
`define BESP_OPT_S_MWI_DISC 8
`define BESP_OPT_LONG_LOCK 9
`define BESP_OPT_S_HOLD_REQ 10
`define BESP_OPT_P_HOLD_REQ 11
// Writable option bits and reset value
`define BESP_OPT_MASK 16'h0f9e
`define BESP_OPT_RESET 16'h0c00
// Retry limit default
`define BESP_RETRY_RESET 32'h0100_0000
// Widths
`define BESP_CAUSES 8
`endif

// ==== inc/besp_pkg.sv ====
package besp_pkg;
  typedef logic [7:0] besp_cause_t;
  typedef logic [31:0] besp_word_t;
  // PCI memory command encodings
  typedef enum logic [3:0] {
    BESP_PLAIN_MEMORY_READ_CMD = 4'b0110,
    BESP_PLAIN_MEMORY_WRITE_CMD = 4'b0111,
    BESP_MEMORY_READ_MULTIPLE_CMD = 4'b1100,
    BESP_MEMORY_READ_LINE_CMD = 4'b1110,
    BESP_MEMORY_WRITE_INVALIDATE_CMD = 4'b1111
  } besp_cmd_e;
endpackage : besp_pkg

// ==== hw/besp_match.sv ====
`timescale 1ns/1ps
`include "besp_regs.svh"
// Retry command matcher for one port
module besp_match
  import besp_pkg::*;
(
  input wire logic [3:0] pend_cmd,
  input wire logic [3:0] retry_cmd,
  input wire logic rd_alias,
  input wire logic wr_alias,
  output logic hit
);
  // Exact match, or alias of read-line/multiple and write-invalidate
  always_comb
  begin
    hit = (pend_cmd == retry_cmd);
    if (rd_alias && pend_cmd == BESP_PLAIN_MEMORY_READ_CMD &&
        (retry_cmd == BESP_MEMORY_READ_LINE_CMD || retry_cmd == BESP_MEMORY_READ_MULTIPLE_CMD))
    begin
      hit = 1'b1;
    end
    if (wr_alias && pend_cmd == BESP_PLAIN_MEMORY_WRITE_CMD &&
        retry_cmd == BESP_MEMORY_WRITE_INVALIDATE_CMD)
    begin
      hit = 1'b1;
    end
  end
endmodule : besp_match

// ==== hw/besp_top.sv ====
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "besp_regs.svh"
module besp_top
  import besp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] CAUSE_EVENT,
  input wire logic [7:0] CAUSE_MASK,
  input wire logic SERR_ENABLE,
  output logic PRIMARY_SYSTEM_ERROR_OUT,
  input wire logic [3:0] P_PEND_CMD,
  input wire logic [3:0] P_RETRY_CMD,
  output logic P_RETRY_HIT,
  input wire logic [3:0] S_PEND_CMD,
  input wire logic [3:0] S_RETRY_CMD,
  output logic S_RETRY_HIT,
  output logic P_MWI_TO_PLAIN_MEMORY_WRITE_CMD,
  output logic P_MWI_DISCONNECT,
  output logic S_MWI_TO_PLAIN_MEMORY_WRITE_CMD,
  output logic S_MWI_DISCONNECT,
  output logic LONG_LOCK_REQ,
  input wire logic P_FRAME_SEEN,
  input wire logic P_FIFO_PENDING,
  input wire logic P_TARGET_TERM,
  input wire logic P_REQ_START,
  output logic P_REQ_ACTIVE,
  input wire logic S_FRAME_SEEN,
  input wire logic S_FIFO_PENDING,
  input wire logic S_TARGET_TERM,
  input wire logic S_REQ_START,
  output logic S_REQ_ACTIVE,
  output logic [31:0] RETRY_LIMIT
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic wr_en;
  logic rd_en;
  logic hit_status;
  logic hit_option;
  logic hit_retry;
  besp_cause_t status;
  besp_cause_t fire;
  logic [15:0] option;
  besp_word_t retry_limit;

  assign hit_status = (PADDR == `BESP_ADDR_STATUS);
  assign hit_option = (PADDR == `BESP_ADDR_OPTION);
  assign hit_retry = (PADDR == `BESP_ADDR_RETRY);
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  // Zero wait state slave, unmapped address answers with error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !(hit_status || hit_option || hit_retry);

  // Byte-lane write merge
  function automatic besp_word_t merge(input besp_word_t old, input besp_word_t nw,
                                       input logic [3:0] strb);
    besp_word_t r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Error output and cause status
  // Output asserted for unmasked causes when the command enable is set
  assign fire = CAUSE_EVENT & ~CAUSE_MASK & {`BESP_CAUSES{SERR_ENABLE}};
  assign PRIMARY_SYSTEM_ERROR_OUT = |fire;

  logic [7:0] clr;
  assign clr = (wr_en && hit_status && PSTRB[`BESP_ST_STRB_LANE]) ?
               PWDATA[`BESP_ST_CAUSE_MSB:`BESP_ST_CAUSE_LSB] : 8'h00;

  // Sticky causes; a new event wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      status <= 8'h00;
    end
    else
    begin
      // Bits 16..23: addr parity, posted parity, posted nondelivery,
      // target abort, master abort, delayed write, delayed read, master timeout
      status <= (status & ~clr) | fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option and retry registers
  logic [15:0] option_wr;
  // Option word after a write, reserved bits forced low
  assign option_wr = 16'(merge({16'h0000, option}, PWDATA, PSTRB)) & `BESP_OPT_MASK;

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      option <= `BESP_OPT_RESET;
    end
    else if (wr_en && hit_option)
    begin
      option <= option_wr;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      retry_limit <= `BESP_RETRY_RESET;
    end
    else if (wr_en && hit_retry)
    begin
      retry_limit <= merge(retry_limit, PWDATA, PSTRB);
    end
  end
  assign RETRY_LIMIT = retry_limit;

  // Read data register
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA <= 32'h0000_0000;
    end
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      if (hit_status)
      begin
        PRDATA <= {8'h00, status, 16'h0000};
      end
      else if (hit_option)
      begin
        PRDATA <= {16'h0000, option};
      end
      else if (hit_retry)
      begin
        PRDATA <= retry_limit;
      end
      else
      begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retry command matching
  besp_match u_match_p (
    .pend_cmd(P_PEND_CMD),
    .retry_cmd(P_RETRY_CMD),
    .rd_alias(option[`BESP_OPT_P_RD_ALIAS]),
    .wr_alias(option[`BESP_OPT_P_WR_ALIAS]),
    .hit(P_RETRY_HIT)
  );
  besp_match u_match_s (
    .pend_cmd(S_PEND_CMD),
    .retry_cmd(S_RETRY_CMD),
    .rd_alias(option[`BESP_OPT_S_RD_ALIAS]),
    .wr_alias(option[`BESP_OPT_S_WR_ALIAS]),
    .hit(S_RETRY_HIT)
  );

  // Write-invalidate handling and lock mode
  assign P_MWI_TO_PLAIN_MEMORY_WRITE_CMD = !option[`BESP_OPT_P_MWI_DISC];
  assign P_MWI_DISCONNECT = option[`BESP_OPT_P_MWI_DISC];
  assign S_MWI_TO_PLAIN_MEMORY_WRITE_CMD = !option[`BESP_OPT_S_MWI_DISC];
  assign S_MWI_DISCONNECT = option[`BESP_OPT_S_MWI_DISC];
  assign LONG_LOCK_REQ = option[`BESP_OPT_LONG_LOCK];

  ////////////////////////////////////////////////////////////////////////////
  // Request holding for internal masters
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      P_REQ_ACTIVE <= 1'b0;
    end
    else if (P_REQ_START)
    begin
      P_REQ_ACTIVE <= 1'b1;
    end
    else if (P_REQ_ACTIVE)
    begin
      if (option[`BESP_OPT_P_HOLD_REQ])
      begin
        P_REQ_ACTIVE <= P_FIFO_PENDING && !P_TARGET_TERM;
      end
      else
      begin
        P_REQ_ACTIVE <= !P_FRAME_SEEN;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_REQ_ACTIVE <= 1'b0;
    end
    else if (S_REQ_START)
    begin
      S_REQ_ACTIVE <= 1'b1;
    end
    else if (S_REQ_ACTIVE)
    begin
      if (option[`BESP_OPT_S_HOLD_REQ])
      begin
        S_REQ_ACTIVE <= S_FIFO_PENDING && !S_TARGET_TERM;
      end
      else
      begin
        S_REQ_ACTIVE <= !S_FRAME_SEEN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_status_sets: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    |fire |=> ((status & $past(fire)) == $past(fire)))
    else $error("status cause not captured");
  chk_status_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (clr[0] && !fire[0]) |=> !status[0])
    else $error("status bit not cleared");
  chk_status_keep: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (status[7] && !clr[7]) |=> status[7])
    else $error("status bit lost");
  chk_serr_gate: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !SERR_ENABLE |-> !PRIMARY_SYSTEM_ERROR_OUT)
    else $error("error output while disabled");
  chk_opt_reserved: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (option & ~`BESP_OPT_MASK) == 16'h0000)
    else $error("reserved option bit set");
  chk_mwi_mode: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    P_MWI_DISCONNECT != P_MWI_TO_PLAIN_MEMORY_WRITE_CMD)
    else $error("write invalidate mode conflict");
  chk_p_release: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (P_REQ_ACTIVE && !P_REQ_START && !option[`BESP_OPT_P_HOLD_REQ] && P_FRAME_SEEN)
    |=> !P_REQ_ACTIVE)
    else $error("primary request not released");
  chk_s_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (S_REQ_ACTIVE && option[`BESP_OPT_S_HOLD_REQ] && S_FIFO_PENDING && !S_TARGET_TERM)
    |=> S_REQ_ACTIVE)
    else $error("secondary request dropped early");
  chk_retry_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_en && hit_retry && PSTRB == 4'hf) |=> (retry_limit == $past(PWDATA)))
    else $error("retry limit not written");
  chk_s_release: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (S_REQ_ACTIVE && !S_REQ_START && !option[`BESP_OPT_S_HOLD_REQ] && S_FRAME_SEEN)
    |=> !S_REQ_ACTIVE)
    else $error("secondary request not released");
  chk_p_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (P_REQ_ACTIVE && option[`BESP_OPT_P_HOLD_REQ] && P_FIFO_PENDING && !P_TARGET_TERM)
    |=> P_REQ_ACTIVE)
    else $error("primary request dropped early");
  chk_p_exact: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !(option[`BESP_OPT_P_RD_ALIAS] || option[`BESP_OPT_P_WR_ALIAS]) |->
    (P_RETRY_HIT == (P_PEND_CMD == P_RETRY_CMD)))
    else $error("primary retry match not exact");
  chk_s_exact: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !(option[`BESP_OPT_S_RD_ALIAS] || option[`BESP_OPT_S_WR_ALIAS]) |->
    (S_RETRY_HIT == (S_PEND_CMD == S_RETRY_CMD)))
    else $error("secondary retry match not exact");
  chk_opt_read_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (PSEL && !PENABLE && !PWRITE && hit_option) |=>
    ((PRDATA & ~{16'h0000, `BESP_OPT_MASK}) == 32'h0000_0000))
    else $error("reserved option bits read back set");
  chk_status_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (PSEL && !PENABLE && !PWRITE && hit_status) |=>
    (PRDATA == {8'h00, $past(status), 16'h0000}))
    else $error("status read data wrong");
endmodule : besp_top

// ==== bench/besp_pci_agent.sv ====
`timescale 1ns/1ps
// Far-side bus master: request, one frame, then FIFO drain or target abort
module besp_pci_agent #(parameter int DRAIN = 4, parameter int TERM_AT = 3)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic abort,
  output logic req_start,
  output logic frame_seen,
  output logic fifo_pending,
  output logic target_term
);
  int cnt;
  // Step through one transfer after each go
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
    end
    else if (go)
    begin
      cnt <= 1;
    end
    else if (cnt != 0 && cnt < DRAIN + 2)
    begin
      cnt <= cnt + 1;
    end
    else
    begin
      cnt <= 0;
    end
  end
  // Phases of the transfer
  assign req_start = (cnt == 1);
  assign frame_seen = (cnt == 2);
  assign fifo_pending = (cnt >= 2) && (cnt < DRAIN + 2);
  // Target ends the transfer early when asked to
  assign target_term = abort && (cnt == TERM_AT);
endmodule : besp_pci_agent

// ==== bench/besp_top_tb.sv ====
`timescale 1ns/1ps
module besp_top_tb;
  import besp_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, serr_en = 0, pgo = 0, sgo = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata, rlim;
  logic [7:0] ev = '0, mask = '0;
  logic [3:0] pp = 4'h6, pr = 4'h6, sp = 4'h6, sr = 4'h6;
  logic pready, pslverr, serr_out, phit, shit, p_cv, p_dc, s_cv, s_dc, llock;
  logic pfr, pfp, ptt, pst, pact, sfr, sfp, stt, sst, sact;
  logic pab = 0, sab = 0;
  logic [3:0] pstrb = 4'hf;
  int n_mismatch = 0, compares = 0;
  ////////////////////////////////////////
  besp_top i_besp_top (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CAUSE_EVENT(ev), .CAUSE_MASK(mask),
    .SERR_ENABLE(serr_en), .PRIMARY_SYSTEM_ERROR_OUT(serr_out), .P_PEND_CMD(pp),
    .P_RETRY_CMD(pr), .P_RETRY_HIT(phit), .S_PEND_CMD(sp), .S_RETRY_CMD(sr),
    .S_RETRY_HIT(shit), .P_MWI_TO_PLAIN_MEMORY_WRITE_CMD(p_cv), .P_MWI_DISCONNECT(p_dc),
    .S_MWI_TO_PLAIN_MEMORY_WRITE_CMD(s_cv), .S_MWI_DISCONNECT(s_dc), .LONG_LOCK_REQ(llock),
    .P_FRAME_SEEN(pfr), .P_FIFO_PENDING(pfp), .P_TARGET_TERM(ptt), .P_REQ_START(pst),
    .P_REQ_ACTIVE(pact), .S_FRAME_SEEN(sfr), .S_FIFO_PENDING(sfp), .S_TARGET_TERM(stt),
    .S_REQ_START(sst), .S_REQ_ACTIVE(sact), .RETRY_LIMIT(rlim));
  besp_pci_agent i_besp_pci_agent (.clk(clk), .rst_n(rst_n), .go(pgo), .abort(pab),
    .req_start(pst), .frame_seen(pfr), .fifo_pending(pfp), .target_term(ptt));
  besp_pci_agent i_besp_pci_agent_s (.clk(clk), .rst_n(rst_n), .go(sgo), .abort(sab),
    .req_start(sst), .frame_seen(sfr), .fifo_pending(sfp), .target_term(stt));
  // 20 MHz clock
  always #25 clk = ~clk;
  ////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; read data and error taken at the ready edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task t_regs;
    apb(0, 12'h068, 0);
    chk("status", 0, rd);
    apb(0, 12'h074, 0);
    chk("option", 32'h0000_0c00, rd);
    apb(0, 12'h078, 0);
    chk("retry", 32'h0100_0000, rd);
    chk("mwi", 5'b10100, {p_cv, p_dc, s_cv, s_dc, llock});
    apb(1, 12'h074, 32'hffff_ffff);
    apb(0, 12'h074, 0);
    chk("option", 32'h0000_0f9e, rd);
    chk("mwi", 5'b01011, {p_cv, p_dc, s_cv, s_dc, llock});
    // Low byte lane only: the upper option byte keeps its bits
    pstrb <= 4'h1;
    apb(1, 12'h074, 32'h0000_0000);
    pstrb <= 4'hf;
    apb(0, 12'h074, 0);
    chk("option", 32'h0000_0f00, rd);
    apb(1, 12'h078, 32'h1234_5678);
    apb(0, 12'h078, 0);
    chk("retry", 32'h1234_5678, rd);
    chk("retry_out", 32'h1234_5678, rlim);
    apb(0, 12'h07c, 0);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
  endtask : t_regs
  task t_status;
    logic [31:0] b;
    serr_en <= 1'b1;
    mask <= 8'hff;
    ev <= 8'hff;
    @(posedge clk);
    chk("serr_out", 0, serr_out);
    serr_en <= 1'b0;
    mask <= 8'h00;
    @(posedge clk);
    chk("serr_out", 0, serr_out);
    ev <= 8'h00;
    serr_en <= 1'b1;
    apb(0, 12'h068, 0);
    chk("status", 0, rd);
    for (int i = 0; i < 8; i++)
    begin
      b = 32'h0000_0001 << (16 + i);
      ev <= 8'h01 << i;
      @(posedge clk);
      chk("serr_out", 1, serr_out);
      ev <= 8'h00;
      apb(0, 12'h068, 0);
      chk("cause", b, rd);
      apb(1, 12'h068, ~b);
      apb(0, 12'h068, 0);
      chk("cause", b, rd);
      apb(1, 12'h068, b);
      apb(0, 12'h068, 0);
      chk("cause", 0, rd);
    end
    // A clear meeting a new event at the access edge loses to the event
    fork
      apb(1, 12'h068, 32'h0080_0000);
      begin
        repeat (2) @(posedge clk);
        ev <= 8'h80;
        @(posedge clk);
        ev <= 8'h00;
      end
    join
    apb(0, 12'h068, 0);
    chk("cause", 32'h0080_0000, rd);
    // Status byte lane switched off: the clear does nothing
    pstrb <= 4'hb;
    apb(1, 12'h068, 32'h0080_0000);
    pstrb <= 4'hf;
    apb(0, 12'h068, 0);
    chk("cause", 32'h0080_0000, rd);
    apb(1, 12'h068, 32'h0080_0000);
    apb(0, 12'h068, 0);
    chk("cause", 0, rd);
  endtask : t_status
  task t_match;
    logic [3:0] pt [4] = '{4'h6, 4'h6, 4'h7, 4'h7};
    logic [3:0] rt [4] = '{4'he, 4'hc, 4'hf, 4'h7};
    for (int k = 0; k < 2; k++)
    begin
      apb(1, 12'h074, k ? 32'h0000_0018 : 32'h0000_0006);
      for (int j = 0; j < 4; j++)
      begin
        pp <= pt[j];
        sp <= pt[j];
        pr <= rt[j];
        sr <= rt[j];
        @(posedge clk);
        chk("p_hit", j == 3 || k == 0, phit);
        chk("s_hit", j == 3 || k == 1, shit);
      end
    end
  endtask : t_match
  // Count the cycles a port holds its request for one transfer
  task req_run(input logic prim, input logic ab, input int exp);
    int c;
    c = 0;
    @(posedge clk);
    pgo <= prim;
    sgo <= !prim;
    pab <= ab && prim;
    sab <= ab && !prim;
    @(posedge clk);
    pgo <= 1'b0;
    sgo <= 1'b0;
    repeat (12)
    begin
      @(posedge clk);
      c += prim ? (pact === 1'b1) : (sact === 1'b1);
    end
    chk("req_cycles", exp, c);
  endtask : req_run
  task t_req;
    apb(1, 12'h074, 32'h0000_0400);
    req_run(1, 0, 1);
    req_run(0, 0, 5);
    apb(1, 12'h074, 32'h0000_0800);
    req_run(1, 0, 5);
    req_run(0, 0, 1);
    // Target termination ends a held request before the drain
    apb(1, 12'h074, 32'h0000_0c00);
    req_run(1, 1, 2);
    req_run(0, 1, 2);
  endtask : t_req
  task results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_status;
    t_match;
    t_req;
    results;
  end
  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results;
  end
endmodule : besp_top_tb
